// ### design/motor_step_pkg.sv
// Package for the scanner stepper-motor step controller.
// Assumes a single 50 MHz clock and a classic Wishbone register bus.
package motor_step_pkg;

  // ==========================================================
  // Register map (printed offsets are word indices)
  // ==========================================================
  localparam logic [7:0] REG_CTRL_IDX     = 8'h07;  // Scan start, standby
  localparam logic [7:0] REG_MOTOR_IDX    = 8'h45;  // Output enable, swap, fastfeed
  localparam logic [7:0] REG_REVERSE_IDX  = 8'h50;  // Steps to back up on pause
  localparam logic [7:0] REG_ACCEL_IDX    = 8'h51;  // Acceleration dwell codes
  localparam logic [7:0] REG_KICK_IDX     = 8'h55;  // Kickstart step count
  localparam logic [7:0] REG_LIMCFG_IDX   = 8'h58;  // Step limit disable bit
  localparam logic [7:0] REG_LIMIT_IDX    = 8'h60;  // Fullstep limit value
  localparam logic [7:0] REG_STATUS_IDX   = 8'h61;  // Motor status readback
  localparam logic [7:0] REG_CMD_IDX      = 8'h62;  // Motion commands

  // ==========================================================
  // Field positions
  // ==========================================================
  localparam int CTRL_SCAN_BIT     = 0;  // Scan running
  localparam int CTRL_STANDBY_BIT  = 4;  // Standby
  localparam int MOTOR_OE_BIT      = 4;  // Drive outputs enabled
  localparam int MOTOR_SWAP_BIT    = 5;  // Swap A and B phases
  localparam int MOTOR_FFEED_BIT   = 6;  // Fullstep fastfeed
  localparam int LIMCFG_DIS_BIT    = 5;  // 1 disables the fullstep limit
  localparam int CMD_REVERSE_BIT   = 0;  // High speed reverse
  localparam int CMD_STOP_BIT      = 1;  // Stop reverse
  localparam int CMD_PAUSE_BIT     = 2;  // Buffer-full pause
  localparam int CMD_RESUME_BIT    = 3;  // Resume after pause

  // ==========================================================
  // Reset values and constants
  // ==========================================================
  localparam logic [7:0] REVERSE_RESET = 8'h00;
  localparam logic [7:0] ACCEL_RESET   = 8'h00;
  localparam logic [2:0] KICK_RESET    = 3'h0;
  localparam logic [3:0] DWELL_CODE3   = 4'h8;  // Code 3 dwells eight fullsteps
  localparam int         ADDR_W        = 10;    // Byte address width
  localparam int         CLK_HZ        = 50_000_000;
  localparam int         STEP_TIME_US  = 1000;  // Default fullstep period
  localparam int         STEP_CYCLES   = CLK_HZ / 1_000_000 * STEP_TIME_US;

  // Motion state machine
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_STOP  = 6'b000010,
    ST_QTR   = 6'b000100,
    ST_HALF  = 6'b001000,
    ST_RUN   = 6'b010000,
    ST_BACK  = 6'b100000
  } motion_t;

  // Dwell fullsteps for a two-bit acceleration code
  function automatic logic [3:0] dwell_steps(input logic [1:0] code);
    dwell_steps = (code == 2'h3) ? DWELL_CODE3 : {2'h0, code};
  endfunction

endpackage

// ### design/step_phase_gen.sv
// Winding phase generator for a two-phase stepper.
// Assumes a one-cycle step enable on the same clock as the caller.
`timescale 1ns/1ns
module step_phase_gen (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Step control
  input  wire logic       stepEn,    // One-cycle advance pulse
  input  wire logic       dirRev,    // Step backwards
  input  wire logic       swapAb,    // Exchange A and B windings
  input  wire logic       fullMode,  // Fullstep mode active
  // Phase outputs
  output logic      [1:0] phaseA_q,  // A winding polarity pair
  output logic      [1:0] phaseB_q   // B winding polarity pair
);
  // ==========================================================
  // Position counter
  // ==========================================================
  logic [1:0] pos_q;       // Quadrature position
  logic [1:0] posNext;     // Next position
  logic [1:0] rawA;        // Unswapped A drive
  logic [1:0] rawB;        // Unswapped B drive
  logic       doSwap;      // Swap applies only in fullstep

  assign posNext = dirRev ? pos_q - 2'h1 : pos_q + 2'h1;
  assign rawA    = pos_q[1] ? 2'b10 : 2'b01;
  assign rawB    = (pos_q[1] ^ pos_q[0]) ? 2'b10 : 2'b01;
  assign doSwap  = swapAb && fullMode;

  // Advance position on each step
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pos_q <= 2'h0;
    end else if (stepEn) begin
      pos_q <= posNext;
    end
  end

  // Register drive, swapping phases to reverse travel
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phaseA_q <= 2'h0;
      phaseB_q <= 2'h0;
    end else begin
      phaseA_q <= doSwap ? rawB : rawA;
      phaseB_q <= doSwap ? rawA : rawB;
    end
  end
endmodule

// ### design/scan_motor_step_controller.sv
// Stepper sequencing for a scanner carriage, with Wishbone registers.
// Assumes a 50 MHz clock; power stage and sense comparators are external.
//
// Behaviour
// - Limit enabled: count fullsteps, stop scan.
// - Eight-bit reverse count on buffer-full pause.
// - Dwell code three holds eight fullsteps.
// - Phase swap reverses travel, fullstep only.
// - Normal 0.35 V threshold, 0.5 V kickstart.
// - Kickstart zero: 0.5 V for all fullsteps.
// - Fastfeed fullstep, microstep once capture begins.
// - Media sensor two never ends reverse.
// - Pause and resume never drops lines.
// - Standby tristates drive, overriding enable bit.
//
// The Wishbone interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
module scan_motor_step_controller
  import motor_step_pkg::*;
#(
  parameter int STEP_DIV = STEP_CYCLES  // Cycles per fullstep
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Wishbone slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  input  wire logic [3:0]        wb_sel_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Media sensor and capture state
  input  wire logic              mediaSense2,   // Pin, unused by reverse
  input  wire logic              captureBegin,  // Image capture started
  // Motor drive
  output logic      [1:0]        phaseA_q,
  output logic      [1:0]        phaseB_q,
  output logic                   driveOe_n_q,   // Low while driving
  output logic                   senseHigh_q,   // 1 selects 0.5 V threshold
  output logic                   microStep_q,   // 1 selects microstepping
  output logic                   lineDrop_q     // Always zero: no lost line
);
  import motor_step_pkg::*;

  // ==========================================================
  // Registers
  // ==========================================================
  logic [7:0]  ctrl_q;      // Scan and standby
  logic [7:0]  motor_q;     // Output enable, swap, fastfeed
  logic [7:0]  reverse_q;   // Reverse steps
  logic [7:0]  accel_q;     // Dwell codes in bits 2-7
  logic [2:0]  kick_q;      // Kickstart steps
  logic [7:0]  limcfg_q;    // Limit disable in bit 5
  logic [15:0] limit_q;     // Fullstep limit
  logic        revReq_q;    // High speed reverse running
  logic        paused_q;    // Buffer-full pause held
  logic        sense1_q;    // Synchroniser stage one
  logic        sense2_q;    // Synchroniser stage two

  // Bus decode
  logic [7:0] regIdx;
  logic       busReq;
  logic       wrStb;
  logic       mapped;
  assign regIdx = wb_adr_i[ADDR_W-1:2];
  assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrStb  = busReq && wb_we_i && wb_sel_i[0];
  assign mapped = (regIdx == REG_CTRL_IDX) || (regIdx == REG_MOTOR_IDX) ||
                  (regIdx == REG_REVERSE_IDX) || (regIdx == REG_ACCEL_IDX) ||
                  (regIdx == REG_KICK_IDX) || (regIdx == REG_LIMCFG_IDX) ||
                  (regIdx == REG_LIMIT_IDX) || (regIdx == REG_STATUS_IDX) ||
                  (regIdx == REG_CMD_IDX);

  // ==========================================================
  // Motion engine signals
  // ==========================================================
  motion_t     state_q;
  motion_t     state_d;
  logic [31:0] div_q;       // Fullstep divider
  logic        stepTick;    // One-cycle fullstep enable
  logic [3:0]  dwell_q;     // Steps left in dwell phase
  logic [15:0] remain_q;    // Fullsteps left before auto stop
  logic [7:0]  back_q;      // Reverse steps left
  logic [2:0]  kickCnt_q;   // Kickstart steps done
  logic        scanOn;
  logic        scanStart;
  logic        limitHit;
  logic        cmdWr;
  logic        autoStop;
  logic        moving;
  logic        dwellDone;   // Dwell phase used up

  assign scanOn    = ctrl_q[CTRL_SCAN_BIT];
  assign cmdWr     = wrStb && (regIdx == REG_CMD_IDX);
  assign scanStart = wrStb && (regIdx == REG_CTRL_IDX) && wb_dat_i[CTRL_SCAN_BIT] && !scanOn;
  assign limitHit  = !limcfg_q[LIMCFG_DIS_BIT] && (remain_q == 16'h0);
  assign autoStop  = scanOn && limitHit && (state_q == ST_RUN);
  // A pause freezes the run, but the back-up steps still need the divider
  assign moving    = (state_q != ST_IDLE) && (!paused_q || state_q == ST_BACK);
  // The last dwell step leaves the phase, so code 3 gives exactly eight steps
  assign dwellDone = (dwell_q == 4'h0) || (stepTick && dwell_q == 4'h1);
  assign stepTick  = moving && (div_q == 32'(STEP_DIV - 1));

  // Register writes; auto stop clears scan bit after the bus write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= 8'h00; motor_q <= 8'h00; reverse_q <= REVERSE_RESET;
      accel_q <= ACCEL_RESET; kick_q <= KICK_RESET; limcfg_q <= 8'h00;
      limit_q <= 16'h0000;
    end else begin
      if (wrStb) begin
        unique case (regIdx)
          REG_CTRL_IDX:    ctrl_q    <= wb_dat_i[7:0];
          REG_MOTOR_IDX:   motor_q   <= wb_dat_i[7:0];
          REG_REVERSE_IDX: reverse_q <= wb_dat_i[7:0];
          REG_ACCEL_IDX:   accel_q   <= wb_dat_i[7:0];
          REG_KICK_IDX:    kick_q    <= wb_dat_i[2:0];
          REG_LIMCFG_IDX:  limcfg_q  <= wb_dat_i[7:0];
          REG_LIMIT_IDX:   limit_q   <= wb_dat_i[15:0];
          default: ;
        endcase
      end
      if (autoStop) begin
        ctrl_q[CTRL_SCAN_BIT] <= 1'b0;
      end
    end
  end

  // Bus answer one cycle after the request; unmapped reads zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= busReq;
      unique case (regIdx)
        REG_CTRL_IDX:    wb_dat_o <= {24'h0, ctrl_q};
        REG_MOTOR_IDX:   wb_dat_o <= {24'h0, motor_q};
        REG_REVERSE_IDX: wb_dat_o <= {24'h0, reverse_q};
        REG_ACCEL_IDX:   wb_dat_o <= {24'h0, accel_q};
        REG_KICK_IDX:    wb_dat_o <= {29'h0, kick_q};
        REG_LIMCFG_IDX:  wb_dat_o <= {24'h0, limcfg_q};
        REG_LIMIT_IDX:   wb_dat_o <= {16'h0, limit_q};
        REG_STATUS_IDX:  wb_dat_o <= {9'h0, sense2_q, state_q, remain_q};
        default:         wb_dat_o <= 32'h0;
      endcase
    end
  end

  // Sensor pin synchroniser; kept only for status, never stops reverse
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sense1_q <= 1'b0;
      sense2_q <= 1'b0;
    end else begin
      sense1_q <= mediaSense2;
      sense2_q <= sense1_q;
    end
  end

  // ==========================================================
  // Commands: reverse, stop, pause and resume
  // ==========================================================
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      revReq_q <= 1'b0;
      paused_q <= 1'b0;
    end else begin
      if (cmdWr && wb_dat_i[CMD_REVERSE_BIT]) begin
        revReq_q <= 1'b1;
      end else if (cmdWr && wb_dat_i[CMD_STOP_BIT]) begin
        revReq_q <= 1'b0;  // Only software ends reverse
      end
      if (cmdWr && wb_dat_i[CMD_PAUSE_BIT]) begin
        paused_q <= 1'b1;
      end else if (state_q == ST_BACK && back_q == 8'h0 && cmdWr
                   && wb_dat_i[CMD_RESUME_BIT]) begin
        paused_q <= 1'b0;
      end
    end
  end

  // Fullstep divider; while paused only the back-up steps run
  always_ff @(posedge clk) begin
    if (!rst_n || !moving || stepTick) begin
      div_q <= 32'h0;
    end else begin
      div_q <= div_q + 32'h1;
    end
  end

  // ==========================================================
  // Motion state machine
  // ==========================================================
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (scanOn || revReq_q) state_d = ST_STOP;
      ST_STOP: if (dwellDone) state_d = ST_QTR;
      ST_QTR:  if (dwellDone) state_d = ST_HALF;
      ST_HALF: if (dwellDone) state_d = ST_RUN;
      ST_RUN: begin
        if (!scanOn && !revReq_q) state_d = ST_IDLE;
        else if (paused_q) state_d = ST_BACK;
      end
      ST_BACK: if (!paused_q) state_d = ST_RUN;  // Resume at same line
      default: state_d = ST_IDLE;
    endcase
  end

  // State, dwell, countdown and reverse counters
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE; dwell_q <= 4'h0; remain_q <= 16'h0;
      back_q <= 8'h0; kickCnt_q <= 3'h0;
    end else begin
      state_q <= state_d;
      if (state_d != state_q) begin
        unique case (state_d)
          ST_STOP: dwell_q <= dwell_steps(accel_q[3:2]);
          ST_QTR:  dwell_q <= dwell_steps(accel_q[5:4]);
          ST_HALF: dwell_q <= dwell_steps(accel_q[7:6]);
          default: dwell_q <= 4'h0;
        endcase
      end else if (stepTick && dwell_q != 4'h0) begin
        dwell_q <= dwell_q - 4'h1;
      end
      if (scanStart) begin
        remain_q <= limit_q;
      end else if (stepTick && scanOn && state_q == ST_RUN && remain_q != 16'h0) begin
        remain_q <= remain_q - 16'h1;
      end
      if (cmdWr && wb_dat_i[CMD_PAUSE_BIT]) begin
        back_q <= reverse_q;
      end else if (stepTick && state_q == ST_BACK && back_q != 8'h0) begin
        back_q <= back_q - 8'h1;
      end
      if (state_q == ST_IDLE) begin
        kickCnt_q <= 3'h0;
      end else if (stepTick && kickCnt_q != kick_q) begin
        kickCnt_q <= kickCnt_q + 3'h1;
      end
    end
  end

  // ==========================================================
  // Drive mode and current level
  // ==========================================================
  logic fullMode;
  logic backStep;
  logic phaseStep;
  assign fullMode  = !motor_q[MOTOR_FFEED_BIT] || !captureBegin || revReq_q;
  assign backStep  = (state_q == ST_BACK) && back_q != 8'h0;
  assign phaseStep = stepTick && (state_q != ST_BACK || backStep);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      driveOe_n_q <= 1'b1; senseHigh_q <= 1'b0;
      microStep_q <= 1'b0; lineDrop_q  <= 1'b0;
    end else begin
      driveOe_n_q <= ctrl_q[CTRL_STANDBY_BIT] || !motor_q[MOTOR_OE_BIT];
      senseHigh_q <= fullMode && ((kick_q == 3'h0) ||
                     (kickCnt_q != kick_q));
      microStep_q <= !fullMode;
      lineDrop_q  <= 1'b0;
    end
  end

  step_phase_gen u_phase (
    .clk      (clk),
    .rst_n    (rst_n),
    .stepEn   (phaseStep),
    .dirRev   (backStep || revReq_q),
    .swapAb   (motor_q[MOTOR_SWAP_BIT]),
    .fullMode (fullMode),
    .phaseA_q (phaseA_q),
    .phaseB_q (phaseB_q)
  );
endmodule

// ### verification/motor_step_chk_sva.sv
// Checker for the step controller: bus answers and drive outputs.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
module motor_step_chk
  import motor_step_pkg::*;
#(
  parameter int STEP_DIV = STEP_CYCLES  // Cycles per fullstep
) (
  // Clock, reset and bus
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  // Sensors and drive
  input wire logic              mediaSense2,
  input wire logic              captureBegin,
  input wire logic [1:0]        phaseA_q,
  input wire logic [1:0]        phaseB_q,
  input wire logic              driveOe_n_q,
  input wire logic              senseHigh_q,
  input wire logic              microStep_q,
  input wire logic              lineDrop_q
);
  // ==========================================================
  // Shadow of control bits, updated at the edge that takes the write
  logic [7:0] idx;     // Word index of the request
  logic       req;     // Request still waiting for its answer
  logic       wrDone;  // Write taking effect
  logic [7:0] revQ;    // Reverse count last written
  logic       oeQ;     // Output enable bit
  logic       sbQ;     // Standby bit
  logic       ffQ;     // Fastfeed bit
  logic       kzQ;     // Kickstart count is zero
  assign idx    = wb_adr_i[9:2];
  assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wrDone = req && wb_we_i && wb_sel_i[0];
  // Writes without byte lane 0 are ignored by the design, so here too
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      revQ <= REVERSE_RESET;
      oeQ  <= 1'b0;
      sbQ  <= 1'b0;
      ffQ  <= 1'b0;
      kzQ  <= 1'b1;
    end else if (wrDone) begin
      if (idx == REG_REVERSE_IDX) revQ <= wb_dat_i[7:0];
      if (idx == REG_CTRL_IDX) sbQ <= wb_dat_i[CTRL_STANDBY_BIT];
      if (idx == REG_MOTOR_IDX) oeQ <= wb_dat_i[MOTOR_OE_BIT];
      if (idx == REG_MOTOR_IDX) ffQ <= wb_dat_i[MOTOR_FFEED_BIT];
      if (idx == REG_KICK_IDX) kzQ <= (wb_dat_i[2:0] == 3'h0);
    end
  end

  // ==========================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stood longer than one cycle");
  chk_ack_answer: assert property (req |=> wb_ack_o)
    else $error("request not answered in the next cycle");
  chk_reverse_readback: assert property (
    req && !wb_we_i && idx == REG_REVERSE_IDX |=> wb_dat_o[7:0] == revQ)
    else $error("reverse count read back wrong");
  chk_unmapped_zero: assert property (
    req && !wb_we_i && idx == 8'hff |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_drive_gate: assert property (
    !driveOe_n_q |-> $past(oeQ && !sbQ) || $past(oeQ && !sbQ, 2))
    else $error("drive enabled in standby or with enable clear");
  chk_no_drop: assert property (!lineDrop_q)
    else $error("line drop flagged");
  chk_micro_low: assert property (
    microStep_q && $past(microStep_q) |-> !senseHigh_q)
    else $error("high threshold while microstepping");
  chk_fastfeed_full: assert property (
    ffQ && !captureBegin && !$past(captureBegin) |-> !microStep_q)
    else $error("microstepping before capture in fastfeed");
  chk_kick_full: assert property (
    kzQ && !microStep_q && !$stable({phaseA_q, phaseB_q}) |-> ##[0:1] senseHigh_q)
    else $error("low threshold in fullstep with zero kickstart");
  cover property (wrDone && idx == REG_CMD_IDX);
  cover property ($rose(microStep_q));
  cover property (sbQ && driveOe_n_q);
endmodule

bind scan_motor_step_controller motor_step_chk #(.STEP_DIV(STEP_DIV)) chk_u (
  .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mediaSense2(mediaSense2),
  .captureBegin(captureBegin), .phaseA_q(phaseA_q), .phaseB_q(phaseB_q),
  .driveOe_n_q(driveOe_n_q), .senseHigh_q(senseHigh_q), .microStep_q(microStep_q),
  .lineDrop_q(lineDrop_q));

// ### verification/stepper_winding_model.sv
// Two-phase stepper motor seen through its windings.
// Assumes fullstep polarity pairs: 2'b01 one way, 2'b10 the other.
`timescale 1ns/1ns
module stepper_winding_model (
  // Clock
  input wire logic       clk,
  // Winding drive
  input wire logic [1:0] phaseA,
  input wire logic [1:0] phaseB,
  input wire logic       driveOe_n,
  // Travel counts, one per direction
  output int             fwdN,
  output int             backN
);
  logic [1:0] quadQ;  // Rotor quadrant last seen
  logic [1:0] quadD;  // Quadrant from present winding signs
  // Exchanging A and B runs this sequence backwards
  assign quadD = {phaseB == 2'b10, (phaseA == 2'b10) ^ (phaseB == 2'b10)};
  initial begin
    fwdN = 0;
    backN = 0;
    quadQ = 2'h0;
  end
  // A tristated drive counts no travel, though quadQ still follows the windings
  always @(posedge clk) begin
    if (!driveOe_n && quadD != quadQ) begin
      if (quadD - quadQ == 2'h1) fwdN <= fwdN + 1;
      else backN <= backN + 1;
    end
    quadQ <= quadD;
  end
endmodule

// ### verification/test_scan_motor_step_controller.sv
// Self-checking bench for the step controller with a winding model.
// Assumes a 50 MHz clock and a short fullstep period for speed.
`timescale 1ns/1ns
module test_scan_motor_step_controller;
  import motor_step_pkg::*;
  localparam int DIV = 4;  // Fullstep period in cycles
  logic              clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [ADDR_W-1:0] wb_adr_i;
  logic [31:0]       wb_dat_i, wb_dat_o, rdat, seed;
  logic [3:0]        wb_sel_i;
  logic [1:0]        phaseA_q, phaseB_q;
  logic              mediaSense2, captureBegin, driveOe_n_q, senseHigh_q;
  logic              microStep_q, lineDrop_q, fwdDir;
  int                fwdN, backN, f0, b0, miscompares, n_compared;
  logic [31:0]       mdl [256];  // Expected register contents

  scan_motor_step_controller #(.STEP_DIV(DIV)) dut_u (.clk(clk), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .mediaSense2(mediaSense2), .captureBegin(captureBegin), .phaseA_q(phaseA_q),
    .phaseB_q(phaseB_q), .driveOe_n_q(driveOe_n_q), .senseHigh_q(senseHigh_q),
    .microStep_q(microStep_q), .lineDrop_q(lineDrop_q));
  stepper_winding_model motor_u (.clk(clk), .phaseA(phaseA_q), .phaseB(phaseB_q),
    .driveOe_n(driveOe_n_q), .fwdN(fwdN), .backN(backN));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic expire();
    miscompares++;
    conclude();
  endtask
  // Classic cycle: hold everything until ack is sampled, then release
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= d;
    wb_sel_i <= s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) expire();
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d, 4'hf);
    if (idx == REG_REVERSE_IDX) mdl[idx] = {24'h0, d[7:0]};
  endtask
  task automatic rd(input logic [7:0] idx);
    bus(1'b0, idx, 32'h0, 4'hf);
    if (idx == REG_REVERSE_IDX || idx == 8'hff) check("register", rdat, mdl[idx]);
  endtask
  task automatic waitState(input logic [5:0] st);
    for (int n = 0; n < 300 && rdat[21:16] !== st; n++) rd(REG_STATUS_IDX);
    if (rdat[21:16] !== st) expire();
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, mediaSense2, captureBegin} = 6'h0;
    wb_adr_i = '0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    seed = 32'hdafc;
    miscompares = 0;
    n_compared = 0;
    foreach (mdl[i]) mdl[i] = 32'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("drive reset", driveOe_n_q, 32'h1);
    // Full eight-bit range, a lane-0-less write and an unmapped place
    for (int i = 0; i < 6; i++) begin
      seed = xs(seed);
      rd(REG_REVERSE_IDX);
      wr(REG_REVERSE_IDX, (i == 0) ? 32'hff : seed);
    end
    bus(1'b1, REG_REVERSE_IDX, 32'h5a, 4'he);
    rd(REG_REVERSE_IDX);
    bus(1'b1, 8'hff, 32'hff, 4'hf);
    rd(8'hff);
    // Scan one: slowest dwell, limit on, pause and resume mid-run
    wr(REG_REVERSE_IDX, 32'h5);
    wr(REG_ACCEL_IDX, 32'hfc);
    wr(REG_KICK_IDX, 32'h0);
    wr(REG_LIMCFG_IDX, 32'h0);
    wr(REG_LIMIT_IDX, 32'd40);
    wr(REG_MOTOR_IDX, 32'h50);
    wr(REG_CTRL_IDX, 32'h1);
    rd(REG_STATUS_IDX);
    check("remain start", rdat[15:0], 32'd40);
    waitState(ST_RUN);
    check("dwell steps", fwdN + backN >= 24 && fwdN + backN <= 25, 32'h1);
    check("kick zero", senseHigh_q, 32'h1);
    check("fastfeed", microStep_q, 32'h0);
    fwdDir = fwdN > backN;
    b0 = fwdDir ? backN : fwdN;
    wr(REG_CMD_IDX, 32'h4);
    repeat (200) @(posedge clk);
    check("backed up", (fwdDir ? backN : fwdN) - b0, 32'd5);
    check("line kept", lineDrop_q, 32'h0);
    wr(REG_CMD_IDX, 32'h8);
    rd(REG_CTRL_IDX);
    for (int n = 0; n < 500 && rdat[0] !== 1'b0; n++) rd(REG_CTRL_IDX);
    check("scan ended", rdat[0], 32'h0);
    rd(REG_STATUS_IDX);
    check("remain end", rdat[15:0], 32'h0);
    // Scan two: swapped phases, short kickstart, then capture
    wr(REG_LIMCFG_IDX, 32'h20);
    wr(REG_KICK_IDX, 32'h2);
    wr(REG_MOTOR_IDX, 32'h70);
    f0 = fwdN;
    b0 = backN;
    wr(REG_CTRL_IDX, 32'h1);
    rd(REG_STATUS_IDX);
    check("remain reload", rdat[15:0], 32'd40);
    waitState(ST_RUN);
    check("swapped", (fwdN - f0 < backN - b0) == fwdDir, 32'h1);
    check("kick over", senseHigh_q, 32'h0);
    captureBegin <= 1'b1;
    repeat (4) @(posedge clk);
    check("microstep", microStep_q, 32'h1);
    wr(REG_CTRL_IDX, 32'h0);
    wr(REG_MOTOR_IDX, 32'h10);
    captureBegin <= 1'b0;
    // Home run: the second media sensor must not cut it short
    wr(REG_ACCEL_IDX, 32'h0);
    wr(REG_CMD_IDX, 32'h1);
    repeat (20) @(posedge clk);
    mediaSense2 <= 1'b1;
    f0 = fwdN + backN;
    repeat (40) @(posedge clk);
    rd(REG_STATUS_IDX);
    check("still reversing", rdat[21:16], ST_RUN);
    check("sensor seen", rdat[22], 32'h1);
    check("still moving", fwdN + backN > f0, 32'h1);
    wr(REG_CMD_IDX, 32'h2);
    mediaSense2 <= 1'b0;
    // Standby overrides the enable bit
    wr(REG_CTRL_IDX, 32'h10);
    repeat (3) @(posedge clk);
    check("standby", driveOe_n_q, 32'h1);
    wr(REG_CTRL_IDX, 32'h0);
    repeat (3) @(posedge clk);
    check("driving", driveOe_n_q, 32'h0);
    conclude();
  end
endmodule
